/* src/gmcr_redirect.v */
// Purpose: Track hart privilege and guest flag, steer supervisor registers
// Assumes: Pipeline presents mode updates and register accesses as pulses
// Notes:   Access verdicts answer one cycle after the request
//
// Behaviour
// - Guest flag set means guest supervisor or user
// - Guest flag clear means machine, hypervisor or user
// - Two-stage translation follows the guest flag exactly
// - Hypervisor above guest supervisor above guest user
// - Guest supervisor interrupts off at host user
// - Hypervisor level behaves as ordinary supervisor
// - Hypervisor registers unreachable from guest supervisor
// - Guest flag redirects supervisor registers to duplicates
// - Direct duplicate access from guest supervisor raises virtual-instruction
// - Direct duplicate access from user raises illegal
// - Duplicates directly addressable only from machine, hypervisor
// - Host copies idle but kept while guest runs
// - Guest copies idle while guest flag clear
// - Unduplicated registers serve guest levels too
// - Capability bit seven enables feature, writable
// - Thirty-two integer registers, live trap value, paging
`timescale 1ns/100ps
`include "gmcr_consts.vh"

module gmcr_redirect #(
	parameter H_WRITABLE = 1,
	parameter XREG_COUNT = `GMCR_XREG_COUNT
) (
	// Clock and reset
	input  wire        clk,
	input  wire        rst_n,
	// Mode update from trap entry or return
	input  wire        mode_upd_valid,
	input  wire [1:0]  mode_upd_priv,
	input  wire        mode_upd_virt,
	output wire        mode_upd_ready,
	// Capability bit write
	input  wire        isa_h_wr,
	input  wire        isa_h_wr_data,
	// Register access request
	input  wire        csr_req_valid,
	input  wire [11:0] csr_req_addr,
	input  wire        csr_req_write,
	// Register access answer
	output reg         csr_resp_valid_ff,
	output reg  [11:0] csr_resp_addr_ff,
	output reg         csr_resp_redir_ff,
	output reg         csr_resp_illegal_ff,
	output reg         csr_resp_virtual_ff,
	// Guest interrupt enable from guest status copy
	input  wire        guest_sie,
	// Hart state
	output reg  [1:0]  priv_ff,
	output reg         virt_ff,
	output reg         isa_h_ff,
	output reg         mode_upd_err_ff,
	output wire        two_stage_on,
	output wire [1:0]  nominal_priv,
	output reg  [2:0]  priv_rank,
	output wire        level_m,
	output wire        level_hs,
	output wire        level_u,
	output wire        level_vs,
	output wire        level_vu,
	// Steering of register copies
	output wire        guest_copy_active,
	output wire        host_copy_active,
	output wire        shared_sup_level,
	output wire        shared_user_level,
	output wire        guest_irq_global_en,
	// Static capabilities
	output wire [5:0]  cap_xregs,
	output wire        cap_mtval_live,
	output wire        cap_sv39
);

	reg         nxt_priv;
	reg  [1:0]  nxt_priv_code;
	reg         nxt_virt;
	reg         nxt_isa_h;
	reg         nxt_err;
	wire        upd_legal;
	wire [11:0] chk_addr;
	wire        chk_redir;
	wire        chk_ill;
	wire        chk_vins;

	// Updates always accepted; illegal combinations are dropped and flagged
	assign mode_upd_ready = 1'b1;

	// A guest level must be supervisor or user, and needs the feature on
	assign upd_legal = (mode_upd_priv != `GMCR_PRIV_RSVD) &
	                   ~(mode_upd_virt & ~isa_h_ff) &
	                   ~(mode_upd_virt & (mode_upd_priv == `GMCR_PRIV_M));

	// Capability bit: writable unless the build hardwires it
	always @* begin
		nxt_isa_h = isa_h_ff;
		if (isa_h_wr && (H_WRITABLE != 0)) begin
			nxt_isa_h = isa_h_wr_data;
		end
	end

	// Next privilege and guest flag
	always @* begin
		nxt_priv      = 1'b0;
		nxt_priv_code = priv_ff;
		nxt_virt      = virt_ff;
		nxt_err       = 1'b0;
		if (mode_upd_valid) begin
			if (upd_legal) begin
				nxt_priv      = 1'b1;
				nxt_priv_code = mode_upd_priv;
				nxt_virt      = mode_upd_virt;
			end else begin
				nxt_err = 1'b1;
			end
		end
		// Switching the feature off cannot leave the hart inside a guest
		if (~nxt_isa_h) begin
			nxt_virt = 1'b0;
		end
	end

	// State flops; reset lands at machine level with no guest
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			priv_ff         <= `GMCR_PRIV_M;
			virt_ff         <= 1'b0;
			isa_h_ff        <= `GMCR_ISA_H_RST;
			mode_upd_err_ff <= 1'b0;
		end else begin
			priv_ff         <= nxt_priv ? nxt_priv_code : priv_ff;
			virt_ff         <= nxt_virt;
			isa_h_ff        <= nxt_isa_h;
			mode_upd_err_ff <= nxt_err;
		end
	end

	// Translation and nominal privilege are direct views of the state
	assign two_stage_on = virt_ff;
	assign nominal_priv = priv_ff;

	// One-hot level decode
	assign level_m  = (priv_ff == `GMCR_PRIV_M);
	assign level_hs = ~virt_ff & (priv_ff == `GMCR_PRIV_S);
	assign level_u  = ~virt_ff & (priv_ff == `GMCR_PRIV_U);
	assign level_vs =  virt_ff & (priv_ff == `GMCR_PRIV_S);
	assign level_vu =  virt_ff & (priv_ff == `GMCR_PRIV_U);

	// Rank; guest user ranks above host user
	always @* begin
		priv_rank = `GMCR_RANK_U;
		if (level_m) begin
			priv_rank = `GMCR_RANK_M;
		end else if (level_hs) begin
			priv_rank = `GMCR_RANK_HS;
		end else if (level_vs) begin
			priv_rank = `GMCR_RANK_VS;
		end else if (level_vu) begin
			priv_rank = `GMCR_RANK_VU;
		end
	end

	// Exactly one supervisor copy drives behaviour; the other keeps its value
	assign guest_copy_active = virt_ff;
	assign host_copy_active  = ~virt_ff;

	// Shared registers follow nominal level, guest levels standing in
	assign shared_sup_level  = (priv_ff == `GMCR_PRIV_S);
	assign shared_user_level = (priv_ff == `GMCR_PRIV_U);

	// Guest interrupts: gated by guest enable in guest supervisor,
	// always live below it, and off at higher levels and host user
	assign guest_irq_global_en = level_vs ? guest_sie :
	                             level_vu;

	// Access classification
	gmcr_csr_check u_check (
		.addr     (csr_req_addr),
		.wr       (csr_req_write),
		.virt     (virt_ff),
		.priv     (priv_ff),
		.h_en     (isa_h_ff),
		.eff_addr (chk_addr),
		.redir    (chk_redir),
		.ill      (chk_ill),
		.vins     (chk_vins)
	);

	// Verdict register; valid follows the request, other answer fields only change with one
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			csr_resp_valid_ff   <= 1'b0;
			csr_resp_addr_ff    <= 12'h000;
			csr_resp_redir_ff   <= 1'b0;
			csr_resp_illegal_ff <= 1'b0;
			csr_resp_virtual_ff <= 1'b0;
		end else begin
			csr_resp_valid_ff <= csr_req_valid;
			if (csr_req_valid) begin
				csr_resp_addr_ff    <= chk_addr;
				csr_resp_redir_ff   <= chk_redir;
				csr_resp_illegal_ff <= chk_ill;
				csr_resp_virtual_ff <= chk_vins;
			end
		end
	end

	// Fixed capabilities of a hart that offers the feature
	assign cap_xregs      = XREG_COUNT[5:0];
	assign cap_mtval_live = `GMCR_MTVAL_LIVE;
	assign cap_sv39       = `GMCR_SATP_SV39;

endmodule // gmcr_redirect

/* src/gmcr_consts.vh */
// Purpose: Shared constants of the guest mode register redirect block
// Assumes: Twelve-bit register addresses, two-bit privilege codes
// Notes:   Definitions only; included by bare name
`ifndef GMCR_CONSTS_VH
`define GMCR_CONSTS_VH

// Privilege codes
`define GMCR_PRIV_U        2'h0
`define GMCR_PRIV_S        2'h1
`define GMCR_PRIV_RSVD     2'h2
`define GMCR_PRIV_M        2'h3

// Privilege ranking, larger is more privileged
`define GMCR_RANK_U        3'h0
`define GMCR_RANK_VU       3'h1
`define GMCR_RANK_VS       3'h2
`define GMCR_RANK_HS       3'h3
`define GMCR_RANK_M        3'h4

// Address pages, taken from address bits 11:8, and one full register address
`define GMCR_SUP_PAGE      4'h1
`define GMCR_VS_PAGE       4'h2
`define GMCR_HYP_PAGE      4'h6
`define GMCR_HGEIP_ADDR    12'he12

// Low bytes of supervisor registers that own a guest duplicate
`define GMCR_LO_STATUS     8'h00
`define GMCR_LO_IE         8'h04
`define GMCR_LO_TVEC       8'h05
`define GMCR_LO_SCRATCH    8'h40
`define GMCR_LO_EPC        8'h41
`define GMCR_LO_CAUSE      8'h42
`define GMCR_LO_TVAL       8'h43
`define GMCR_LO_IP         8'h44
`define GMCR_LO_ATP        8'h80

// Address fields
`define GMCR_ADDR_PAGE_HI  11
`define GMCR_ADDR_PAGE_LO  8
`define GMCR_ADDR_LVL_HI   9
`define GMCR_ADDR_LVL_LO   8
`define GMCR_ADDR_LVL_HYP  2'h2
`define GMCR_ADDR_IDX_HI   7
`define GMCR_ADDR_IDX_LO   0
`define GMCR_ADDR_RO_HI    11
`define GMCR_ADDR_RO_LO    10
`define GMCR_ADDR_RO_VAL   2'h3

// Capability figures
`define GMCR_ISA_H_BIT     7
`define GMCR_ISA_H_RST     1'h1
`define GMCR_XREG_COUNT    32
`define GMCR_SATP_SV39     1'h1
`define GMCR_MTVAL_LIVE    1'h1

`endif

/* src/gmcr_csr_check.v */
// Purpose: Classify one register access: redirect, illegal, virtual-instruction
// Assumes: Inputs stable for the cycle; purely combinational
// Notes:   Illegal takes priority over virtual-instruction
`timescale 1ns/100ps
`include "gmcr_consts.vh"

module gmcr_csr_check (
	// Access under test
	input  wire [11:0] addr,
	input  wire        wr,
	// Hart state
	input  wire        virt,
	input  wire [1:0]  priv,
	input  wire        h_en,
	// Verdict
	output wire [11:0] eff_addr,
	output wire        redir,
	output wire        ill,
	output wire        vins
);

	wire [3:0] page;
	wire [7:0] lo;
	reg        has_dup;
	wire       is_sdup;
	wire       is_vsaddr;
	wire       is_hyp;
	wire       user_lvl;
	wire       ill_priv;
	wire [1:0] need_lvl;

	assign page = addr[`GMCR_ADDR_PAGE_HI:`GMCR_ADDR_PAGE_LO];
	assign lo   = addr[`GMCR_ADDR_IDX_HI:`GMCR_ADDR_IDX_LO];

	// Only these supervisor registers own a guest copy; others stay shared
	always @* begin
		case (lo)
			`GMCR_LO_STATUS, `GMCR_LO_IE, `GMCR_LO_TVEC,
			`GMCR_LO_SCRATCH, `GMCR_LO_EPC, `GMCR_LO_CAUSE,
			`GMCR_LO_TVAL, `GMCR_LO_IP, `GMCR_LO_ATP: has_dup = 1'b1;
			default: has_dup = 1'b0;
		endcase
	end

	// Address class decode
	assign is_sdup   = h_en & (page == `GMCR_SUP_PAGE) & has_dup;
	assign is_vsaddr = h_en & (page == `GMCR_VS_PAGE) & has_dup;
	assign is_hyp    = h_en & ((page == `GMCR_HYP_PAGE) | (addr == `GMCR_HGEIP_ADDR));
	assign user_lvl  = (priv == `GMCR_PRIV_U);

	// Guest supervisor accesses land on the duplicate page
	assign redir    = virt & is_sdup;
	assign eff_addr = redir ? {`GMCR_VS_PAGE, lo} : addr;

	// Hypervisor level field needs only supervisor while the feature is on
	assign need_lvl = (h_en & (addr[`GMCR_ADDR_LVL_HI:`GMCR_ADDR_LVL_LO] == `GMCR_ADDR_LVL_HYP)) ?
	                  `GMCR_PRIV_S : addr[`GMCR_ADDR_LVL_HI:`GMCR_ADDR_LVL_LO];

	// Level field above current nominal privilege, or write to read-only
	assign ill_priv = (need_lvl > priv) |
	                  (wr & (addr[`GMCR_ADDR_RO_HI:`GMCR_ADDR_RO_LO] == `GMCR_ADDR_RO_VAL));

	// User levels get illegal-instruction for duplicate and hypervisor pages
	assign ill  = ill_priv | (user_lvl & (is_vsaddr | is_hyp));
	// Guest supervisor trying duplicate or hypervisor pages directly
	assign vins = ~ill & virt & (is_vsaddr | is_hyp);

endmodule // gmcr_csr_check

/* testbench/gmcr_redirect_checker.sv */
// Purpose: Port-level assertions on the guest mode register redirect block
// Assumes: One clock domain, rst_n async active low
// Notes:   Bound to every gmcr_redirect instance
`timescale 1ns/100ps

module gmcr_redirect_checker (
	// Clock and reset
	input logic        clk,
	input logic        rst_n,
	// Requests
	input logic        mode_upd_valid,
	input logic [1:0]  mode_upd_priv,
	input logic        csr_req_valid,
	input logic [11:0] csr_req_addr,
	// Answers and state
	input logic        csr_resp_valid_ff,
	input logic [11:0] csr_resp_addr_ff,
	input logic        csr_resp_redir_ff,
	input logic        csr_resp_illegal_ff,
	input logic        csr_resp_virtual_ff,
	input logic        virt_ff,
	input logic        mode_upd_err_ff,
	input logic        two_stage_on,
	input logic [2:0]  priv_rank,
	input logic        level_u,
	input logic        level_vs,
	input logic        level_vu,
	input logic        guest_irq_global_en
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_guest_levels: assert property (virt_ff |-> level_vs || level_vu)
		else $error("guest flag set outside guest levels");
	a_host_levels: assert property (!virt_ff |-> !level_vs && !level_vu)
		else $error("guest level with flag clear");
	a_two_stage: assert property (two_stage_on == virt_ff)
		else $error("two-stage translation off the guest flag");
	a_rank_guest: assert property (level_vs |-> priv_rank == 3'h2)
		else $error("guest supervisor rank wrong");
	a_irq_user_off: assert property (level_u |-> !guest_irq_global_en)
		else $error("guest interrupts enabled at host user");
	a_resp_pulse: assert property (csr_req_valid |=> csr_resp_valid_ff)
		else $error("access answer missing");
	a_redir_addr: assert property (csr_req_valid && virt_ff && csr_req_addr[11:8] == 4'h1
		&& csr_req_addr[7:0] == 8'h00 |=> csr_resp_redir_ff
		&& csr_resp_addr_ff == {4'h2, $past(csr_req_addr[7:0])})
		else $error("supervisor access not steered");
	a_vs_direct: assert property (csr_req_valid && level_vs && csr_req_addr == 12'h200
		|=> csr_resp_virtual_ff && !csr_resp_illegal_ff)
		else $error("direct duplicate access not virtual");
	a_exc_single: assert property (!(csr_resp_illegal_ff && csr_resp_virtual_ff))
		else $error("both exceptions raised");
	a_mode_err: assert property (mode_upd_valid && mode_upd_priv == 2'h2 |=> mode_upd_err_ff)
		else $error("reserved level not refused");

	c_redir: cover property (csr_resp_redir_ff);
	c_virt: cover property (csr_resp_virtual_ff);
	c_vu: cover property (level_vu);
endmodule // gmcr_redirect_checker

bind gmcr_redirect gmcr_redirect_checker chk_u (.clk, .rst_n, .mode_upd_valid, .mode_upd_priv,
	.csr_req_valid, .csr_req_addr, .csr_resp_valid_ff, .csr_resp_addr_ff, .csr_resp_redir_ff,
	.csr_resp_illegal_ff, .csr_resp_virtual_ff, .virt_ff, .mode_upd_err_ff, .two_stage_on,
	.priv_rank, .level_u, .level_vs, .level_vu, .guest_irq_global_en);

/* testbench/gmcr_redirect_tb.sv */
// Purpose: Directed checks of level tracking and register steering
// Assumes: Inputs driven by NBA at rising edge, answers one cycle later
// Notes:   Access flags packed as redirect, illegal, virtual
`timescale 1ns/100ps

module gmcr_redirect_tb;
	logic clk = 0, rst_n = 0, mode_upd_valid = 0, mode_upd_virt = 0, isa_h_wr = 0;
	logic isa_h_wr_data = 0, csr_req_valid = 0, csr_req_write = 0, guest_sie = 1;
	logic [1:0] mode_upd_priv = 0;
	logic [11:0] csr_req_addr = 0;
	wire csr_resp_valid_ff, csr_resp_redir_ff, csr_resp_illegal_ff, csr_resp_virtual_ff;
	wire virt_ff, isa_h_ff, mode_upd_err_ff, two_stage_on, level_m, level_vs, level_vu;
	wire guest_irq_global_en, guest_copy_active, cap_mtval_live, cap_sv39, level_u;
	wire mode_upd_ready, level_hs, host_copy_active, shared_sup_level, shared_user_level;
	wire [11:0] csr_resp_addr_ff;
	wire [1:0] priv_ff, nominal_priv;
	wire [2:0] priv_rank;
	wire [5:0] cap_xregs;
	int fails = 0, n_compared = 0;

	gmcr_redirect dut_u (.clk, .rst_n, .mode_upd_valid, .mode_upd_priv, .mode_upd_virt,
		.mode_upd_ready, .isa_h_wr, .isa_h_wr_data, .csr_req_valid, .csr_req_addr,
		.csr_req_write, .csr_resp_valid_ff, .csr_resp_addr_ff, .csr_resp_redir_ff,
		.csr_resp_illegal_ff, .csr_resp_virtual_ff, .guest_sie, .priv_ff, .virt_ff, .isa_h_ff,
		.mode_upd_err_ff, .two_stage_on, .nominal_priv, .priv_rank, .level_m, .level_hs,
		.level_u, .level_vs, .level_vu, .guest_copy_active, .host_copy_active,
		.shared_sup_level, .shared_user_level, .guest_irq_global_en, .cap_xregs,
		.cap_mtval_live, .cap_sv39);

	// 25 MHz clock
	always #20 clk = ~clk;

	task chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	// One mode update; state is settled on return
	task mode(input logic [1:0] p, input logic v);
		@(posedge clk);
		mode_upd_valid <= 1;
		mode_upd_priv <= p;
		mode_upd_virt <= v;
		@(posedge clk);
		mode_upd_valid <= 0;
		#1;
	endtask

	// One access (read unless w) and its judged answer
	task acc(input logic [11:0] a, input logic [11:0] ea, input logic [2:0] f,
		input logic w = 0);
		@(posedge clk);
		csr_req_valid <= 1;
		csr_req_addr <= a;
		csr_req_write <= w;
		@(posedge clk);
		csr_req_valid <= 0;
		csr_req_write <= 0;
		#1;
		chk("resp_valid", csr_resp_valid_ff, 1);
		chk("resp_addr", csr_resp_addr_ff, ea);
		chk("resp_flags", {csr_resp_redir_ff, csr_resp_illegal_ff, csr_resp_virtual_ff}, f);
	endtask

	// Guest interrupt enable level change, settled on return
	task sie(input logic d);
		@(posedge clk);
		guest_sie <= d;
		@(posedge clk);
		#1;
	endtask

	task cap_wr(input logic d);
		@(posedge clk);
		isa_h_wr <= 1;
		isa_h_wr_data <= d;
		@(posedge clk);
		isa_h_wr <= 0;
		#1;
	endtask

	task close_out;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Watchdog well beyond the 46 cycles of the run
	initial begin
		repeat (3000) @(posedge clk);
		fails++;
		close_out;
	end

	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1;
		#1;
		chk("priv", priv_ff, 3);
		chk("level_m", level_m, 1);
		chk("two_stage", two_stage_on, 0);
		chk("caps", {cap_xregs, cap_mtval_live, cap_sv39}, {6'h20, 2'h3});
		chk("ready", mode_upd_ready, 1);
		acc(12'h200, 12'h200, 0);
		mode(1, 0);
		chk("rank_hs", priv_rank, 3);
		chk("nominal", nominal_priv, 1);
		chk("hs", {level_hs, host_copy_active, guest_copy_active, shared_sup_level}, 4'hd);
		acc(12'h600, 12'h600, 0);
		acc(12'h200, 12'h200, 0);
		acc(12'h241, 12'h241, 0, 1);
		acc(12'hc00, 12'hc00, 2, 1);
		mode(1, 1);
		chk("vs", {level_vs, two_stage_on, guest_copy_active}, 3'h7);
		chk("vs_host", {host_copy_active, shared_sup_level, level_hs}, 3'h2);
		chk("rank_vs", priv_rank, 2);
		chk("irq_vs", guest_irq_global_en, 1);
		sie(0);
		chk("irq_vs_off", guest_irq_global_en, 0);
		acc(12'h100, 12'h200, 4);
		acc(12'h141, 12'h241, 4);
		acc(12'h200, 12'h200, 1);
		acc(12'h600, 12'h600, 1);
		mode(0, 1);
		chk("vu", {level_vu, priv_rank}, 4'h9);
		chk("nominal", nominal_priv, 0);
		chk("vu_shared", shared_user_level, 1);
		chk("irq_vu", guest_irq_global_en, 1);
		acc(12'h200, 12'h200, 2);
		mode(0, 0);
		chk("irq_u", guest_irq_global_en, 0);
		acc(12'h200, 12'h200, 2);
		mode(2, 0);
		chk("err_rsvd", {mode_upd_err_ff, priv_ff}, 3'h4);
		mode(3, 1);
		chk("err_mv", {mode_upd_err_ff, virt_ff}, 2'h2);
		mode(1, 1);
		cap_wr(0);
		chk("cap_off", {isa_h_ff, virt_ff}, 0);
		mode(1, 1);
		chk("err_off", {mode_upd_err_ff, virt_ff}, 2'h2);
		cap_wr(1);
		chk("cap_on", isa_h_ff, 1);
		close_out;
	end
endmodule // gmcr_redirect_tb
